// >>> pkg/clock_monitor_pkg.sv
// Constants, register map and types shared by the clock monitor
package clock_monitor_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses on the Wishbone bus
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_OSC_CONTROL    = 8'h00;
  localparam logic [7:0] ADDR_OSC_TUNING     = 8'h04;
  localparam logic [7:0] ADDR_INT_ENABLE_TWO = 8'h08;
  localparam logic [7:0] ADDR_INT_FLAG_TWO   = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int         CTRL_FREQ_LSB     = 4;  // internal_freq_select, 3 bits
  localparam int         CTRL_STATUS_BIT   = 3;  // startup_timeout_status
  localparam int         CTRL_HF_READY_BIT = 2;  // High-speed source stable
  localparam int         CTRL_LF_READY_BIT = 1;  // Low-speed source stable
  localparam int         CTRL_SEL_BIT      = 0;  // sys_clock_select
  localparam int         OSC_FAIL_BIT      = 7;  // Same bit in enable and flag regs
  localparam logic [7:0] TUNE_MASK         = 8'h1F;
  localparam logic [7:0] INT_MASK          = 8'hFD;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] FREQ_SEL_RESET = 3'h6;  // 4 MHz internal
  localparam logic [7:0] TUNE_RESET     = 8'h00;
  localparam logic [7:0] INT_RESET      = 8'h00;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 20000000;
  localparam int LF_OSC_HZ     = 31000;     // Nominal, uncalibrated
  localparam int SAMPLE_DIV    = 64;        // Low-speed source to sample clock
  localparam int SAMPLE_HALF   = SAMPLE_DIV / 2;
  localparam int STARTUP_COUNT = 1024;      // External oscillations to count

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CRYSTAL_LOW_POWER_MODE  = 3'b000,
    CRYSTAL_MEDIUM_MODE     = 3'b001,
    CRYSTAL_HIGH_SPEED_MODE = 3'b010,
    DRIVEN_CLOCK_INPUT_MODE = 3'b011,
    RESISTOR_CAPACITOR_MODE = 3'b100,
    RESISTOR_CAP_IO_MODE    = 3'b101
  } osc_mode_t;

  typedef enum logic [1:0] {
    ST_SLEEP   = 2'b00,
    ST_STARTUP = 2'b01,
    ST_RUN     = 2'b10
  } run_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

endpackage

// >>> logic/fail_safe_clock_monitor.sv
// Fail-safe clock monitor with start-up timer and Wishbone registers
`timescale 1ns/1ps

module fail_safe_clock_monitor
  import clock_monitor_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_COUNT
) (
  input  wire logic       clk_i,                  // System clock, 20 MHz
  input  wire logic       rst_i,                  // Synchronous reset, high
  input  wire wb_req_t    wb_req_i,               // Wishbone request group
  output logic [31:0]     wb_dat_o,               // Wishbone read data
  output logic            wb_ack_o,               // Wishbone acknowledge
  input  wire logic       ext_clk_i,              // Primary external oscillator
  input  wire logic       low_freq_internal_osc_i,// Nominal 31 kHz source
  input  wire logic       fail_safe_enable_cfg_i, // Monitor enable, static
  input  wire osc_mode_t  osc_mode_i,             // External mode, static
  input  wire logic       sleep_i,                // Sleep executed, pulse
  input  wire logic       wake_i,                 // Wake-up from sleep, pulse
  output logic            sys_clk_ext_o,          // 1 external, 0 internal
  output logic [2:0]      internal_freq_select_o, // Internal frequency choice
  output logic [4:0]      osc_tune_o,             // Internal tuning value
  output logic            cpu_hold_o,             // Execution held in start-up
  output logic            irq_o                   // Oscillator fail interrupt
);

  // Terminal counts; the start-up counter is ten bits wide, so the
  // parameter must stay at or below 1024 for the compare to work
  localparam logic [9:0] STARTUP_LAST = 10'(STARTUP_CYCLES - 1);
  localparam logic [4:0] HALF_LAST    = 5'(SAMPLE_HALF - 1);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sync1_q, sync1_d;
  logic [1:0] sync2_q, sync2_d;
  logic [1:0] sync3_q, sync3_d;
  logic [1:0] stable_q, stable_d;
  logic [1:0] prev_q, prev_d;
  logic       ext_fall;
  logic       lf_rise;

  // Three stages; a level counts once stages two and three agree
  // Both pins are far slower than the system clock, so the extra
  // stage costs only latency, never a lost edge. Bit 0 is the
  // external pin, bit 1 the low-speed source.
  // A disagreement between stages two and three keeps the old level,
  // which filters a single metastable sample.
  always_comb begin
    sync1_d  = {low_freq_internal_osc_i, ext_clk_i};
    sync2_d  = sync1_q;
    sync3_d  = sync2_q;
    stable_d = ((sync2_q ~^ sync3_q) & sync3_q) | ((sync2_q ^ sync3_q) & stable_q);
    prev_d   = stable_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q  <= 2'h0;
      sync2_q  <= 2'h0;
      sync3_q  <= 2'h0;
      stable_q <= 2'h0;
      prev_q   <= 2'h0;
    end else begin
      sync1_q  <= sync1_d;
      sync2_q  <= sync2_d;
      sync3_q  <= sync3_d;
      stable_q <= stable_d;
      prev_q   <= prev_d;
    end
  end

  // Edges of the filtered levels
  // Registers clear to zero, so an idle-high external pin gives a
  // rising edge after reset, never a false falling edge.
  assign ext_fall = prev_q[0] & ~stable_q[0];
  assign lf_rise  = ~prev_q[1] & stable_q[1];  // Source is ~31 kHz

  // ----------------------------------------------------------------
  // Sample clock divider and fail detector
  // ----------------------------------------------------------------
  logic [4:0] div_q, div_d;
  logic       sample_q, sample_d;
  logic       latch_q, latch_d;
  logic       fail_seen_q, fail_seen_d;
  logic       sample_rise;
  logic       sample_fall;
  logic       armed;

  // Toggle every 32 source edges, giving a divide by 64
  // The sample clock is never used as a clock: it is a level in the
  // system domain, and its edges are one-cycle strobes.
  // The divider runs whether or not the monitor is armed, so the
  // first check after arming may come early in a half period.
  always_comb begin
    div_d       = div_q;
    sample_d    = sample_q;
    sample_rise = 1'b0;
    sample_fall = 1'b0;
    if (lf_rise) begin
      if (div_q == HALF_LAST) begin
        div_d       = 5'h00;
        sample_d    = ~sample_q;
        sample_rise = ~sample_q;
        sample_fall = sample_q;
      end else begin
        div_d = div_q + 5'h01;
      end
    end
  end

  // Set wins over clear: a coincident external edge proves the clock alive
  always_comb begin
    latch_d = latch_q;
    if (ext_fall) begin
      latch_d = 1'b1;
    end else if (sample_rise) begin
      latch_d = 1'b0;
    end
    // Clear at rising, test at falling: one whole half period with no low
    fail_seen_d = armed & sample_fall & ~latch_q & ~ext_fall;
  end

  // Result registered here before the switch logic reads it
  // One cycle of lag is harmless against a half period of some 20000
  // cycles at 31 kHz and 20 MHz, and keeps the switch free of combinational glitches.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q       <= 5'h00;
      sample_q    <= 1'b0;
      latch_q     <= 1'b0;
      fail_seen_q <= 1'b0;
    end else begin
      div_q       <= div_d;
      sample_q    <= sample_d;
      latch_q     <= latch_d;
      fail_seen_q <= fail_seen_d;
    end
  end

  // ----------------------------------------------------------------
  // Start-up timer and fail condition
  // ----------------------------------------------------------------
  run_state_t state_q, state_d;
  logic [9:0] startup_cnt_q, startup_cnt_d;
  logic       fail_cond_q, fail_cond_d;
  logic       crystal;
  logic       sel_toggle;
  logic       fail_event;

  assign crystal = (osc_mode_i == CRYSTAL_LOW_POWER_MODE) ||
                   (osc_mode_i == CRYSTAL_MEDIUM_MODE) ||
                   (osc_mode_i == CRYSTAL_HIGH_SPEED_MODE);

  // Only armed once running after the timer, and only when enabled
  // Once a failure is latched the detector rests until the condition
  // is cleared, so a dead clock raises the flag only once.
  assign armed = fail_safe_enable_cfg_i & (state_q == ST_RUN) & ~fail_cond_q;
  assign fail_event = fail_seen_q & armed;

  // Next state of the run sequencer
  // Priority, lowest first: normal sequencing, select toggle, sleep.
  // Sleep wins because it aborts any start-up in progress.
  always_comb begin
    state_d       = state_q;
    startup_cnt_d = startup_cnt_q;
    fail_cond_d   = fail_cond_q;
    case (state_q)
      ST_SLEEP: begin
        if (wake_i) begin
          state_d       = ST_STARTUP;
          startup_cnt_d = 10'h000;
        end
      end
      ST_STARTUP: begin
        if (!crystal) begin
          state_d     = ST_RUN;
          fail_cond_d = 1'b0;
        end else if (ext_fall) begin
          if (startup_cnt_q == STARTUP_LAST) begin
            state_d     = ST_RUN;
            fail_cond_d = 1'b0;
          end else begin
            startup_cnt_d = startup_cnt_q + 10'h001;
          end
        end
      end
      ST_RUN: begin
        if (fail_event) begin
          fail_cond_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_STARTUP;
      end
    endcase
    // Toggle restarts the timer; fail condition holds until it expires
    if (sel_toggle && (state_q != ST_SLEEP)) begin
      state_d       = ST_STARTUP;
      startup_cnt_d = 10'h000;
    end
    // Sleep aborts start-up and clears the fail condition
    if (sleep_i) begin
      state_d       = ST_SLEEP;
      startup_cnt_d = 10'h000;
      fail_cond_d   = 1'b0;
    end
  end

  // Reset enters start-up and clears the fail condition
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q       <= ST_STARTUP;
      startup_cnt_q <= 10'h000;
      fail_cond_q   <= 1'b0;
    end else begin
      state_q       <= state_d;
      startup_cnt_q <= startup_cnt_d;
      fail_cond_q   <= fail_cond_d;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave and registers
  // ----------------------------------------------------------------
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [2:0]  freq_sel_q, freq_sel_d;
  logic        clk_sel_q, clk_sel_d;
  logic [7:0]  tune_q, tune_d;
  logic [7:0]  int_en_q, int_en_d;
  logic [7:0]  int_flag_q, int_flag_d;
  logic        wr;
  logic [7:0]  wdat;
  logic [7:0]  ctrl_rd;

  // Write lands on the edge that samples ack, byte lane zero only
  // Each register is eight bits in the low lane of its own word;
  // upper lanes read zero and ignore writes.
  assign wr      = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ack_q & wb_req_i.sel[0];
  assign wdat    = wb_req_i.dat[7:0];
  assign ctrl_rd = {1'b0, freq_sel_q, sys_clk_ext_o, 1'b1, 1'b1, clk_sel_q};
  assign sel_toggle = wr && (wb_req_i.adr == ADDR_OSC_CONTROL) &&
                      (wdat[CTRL_SEL_BIT] != clk_sel_q);

  // One-cycle ack; unmapped addresses ack with zero data
  // Acking unmapped addresses keeps a stray access from hanging the
  // bus; the master must release between transfers, since ack
  // returns two cycles later if the request is held.
  always_comb begin
    ack_d      = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
    rdata_d    = 32'h0000_0000;
    freq_sel_d = freq_sel_q;
    clk_sel_d  = clk_sel_q;
    tune_d     = tune_q;
    int_en_d   = int_en_q;
    int_flag_d = int_flag_q;
    if (wb_req_i.adr == ADDR_OSC_CONTROL) begin
      rdata_d = {24'h00_0000, ctrl_rd};
      if (wr) begin
        freq_sel_d = wdat[CTRL_FREQ_LSB +: 3];
        clk_sel_d  = wdat[CTRL_SEL_BIT];
      end
    end else if (wb_req_i.adr == ADDR_OSC_TUNING) begin
      rdata_d = {24'h00_0000, tune_q};
      if (wr) begin
        tune_d = wdat & TUNE_MASK;
      end
    end else if (wb_req_i.adr == ADDR_INT_ENABLE_TWO) begin
      rdata_d = {24'h00_0000, int_en_q};
      if (wr) begin
        int_en_d = wdat & INT_MASK;
      end
    end else if (wb_req_i.adr == ADDR_INT_FLAG_TWO) begin
      rdata_d = {24'h00_0000, int_flag_q};
      if (wr) begin
        int_flag_d = wdat & INT_MASK;
        // Clearing refused while the fail condition stands
        int_flag_d[OSC_FAIL_BIT] = wdat[OSC_FAIL_BIT] | fail_cond_q;
      end
    end
    // Hardware set wins over a coincident software clear
    if (fail_event) begin
      int_flag_d[OSC_FAIL_BIT] = 1'b1;
    end
    if (!ack_d) begin
      rdata_d = 32'h0000_0000;
    end
  end

  // Frequency select returns to 4 MHz and clock select to 0 on reset
  // Every reset behaves alike; there is no separate power-on state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q      <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      freq_sel_q <= FREQ_SEL_RESET;
      clk_sel_q  <= 1'b0;
      tune_q     <= TUNE_RESET;
      int_en_q   <= INT_RESET;
      int_flag_q <= INT_RESET;
    end else begin
      ack_q      <= ack_d;
      rdata_q    <= rdata_d;
      freq_sel_q <= freq_sel_d;
      clk_sel_q  <= clk_sel_d;
      tune_q     <= tune_d;
      int_en_q   <= int_en_d;
      int_flag_q <= int_flag_d;
    end
  end

  assign wb_ack_o               = ack_q;
  assign wb_dat_o               = rdata_q;
  assign internal_freq_select_o = freq_sel_q;
  assign osc_tune_o             = tune_q[4:0];

  // ----------------------------------------------------------------
  // Clock select, hold and interrupt outputs
  // ----------------------------------------------------------------
  logic ext_q, ext_d;
  logic hold_q, hold_d;
  logic irq_q, irq_d;

  // Built from next values so outputs track state without extra lag
  // The select output reports the source actually in use; an
  // automatic switch never alters the software select bit, so the
  // status bit and the oscillator fail flag (bit 7 of the flag register) are what show a failover.
  // The interrupt is a level that follows flag and enable together.
  always_comb begin
    // External only after the timer, with no failure and select at 0
    ext_d  = (state_d == ST_RUN) & ~fail_cond_d & ~clk_sel_d;
    // Without the monitor a crystal start-up with select at 0 halts execution
    hold_d = (state_d == ST_STARTUP) & crystal & ~fail_safe_enable_cfg_i &
             ~clk_sel_d;
    irq_d  = int_flag_d[OSC_FAIL_BIT] & int_en_d[OSC_FAIL_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_q  <= 1'b0;
      hold_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      ext_q  <= ext_d;
      hold_q <= hold_d;
      irq_q  <= irq_d;
    end
  end

  // Outputs come straight from the registers above
  assign sys_clk_ext_o = ext_q;
  assign cpu_hold_o    = hold_q;
  assign irq_o         = irq_q;

endmodule

// >>> verification/clock_monitor_props.sv
// Port-level checks for the fail-safe clock monitor
`timescale 1ns/1ps
module clock_monitor_props
  import clock_monitor_pkg::*;
(
  input wire logic        clk_i,                  // System clock
  input wire logic        rst_i,                  // Sync reset
  input wire wb_req_t     wb_req_i,               // Bus request
  input wire logic [31:0] wb_dat_o,               // Read data
  input wire logic        wb_ack_o,               // Acknowledge
  input wire logic        ext_clk_i,              // External pin
  input wire logic        low_freq_internal_osc_i,// Slow source
  input wire logic        fail_safe_enable_cfg_i, // Monitor enable
  input wire osc_mode_t   osc_mode_i,             // Oscillator mode
  input wire logic        sleep_i,                // Sleep pulse
  input wire logic        wake_i,                 // Wake pulse
  input wire logic        sys_clk_ext_o,          // Clock source
  input wire logic [2:0]  internal_freq_select_o, // Frequency choice
  input wire logic [4:0]  osc_tune_o,             // Tuning value
  input wire logic        cpu_hold_o,             // Start-up hold
  input wire logic        irq_o                   // Interrupt
);
  // ------------------------------------------------------------
  // Bus and control relations
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_req_i.cyc && wb_req_i.stb))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_dat_upper: assert property (wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_reset_values: assert property ($fell(rst_i) |->
    internal_freq_select_o == FREQ_SEL_RESET && osc_tune_o == 5'h00 && !irq_o)
    else $error("reset values wrong");
  a_sleep_internal: assert property (sleep_i |-> ##[1:2] !sys_clk_ext_o)
    else $error("sleep left external clock");
  a_two_speed: assert property (fail_safe_enable_cfg_i |-> !cpu_hold_o)
    else $error("execution held with monitor on");
endmodule

// >>> verification/ext_osc_model.sv
// Behavioural external oscillator that can be made to fail
`timescale 1ns/1ps
module ext_osc_model #(
  parameter int HALF_NS = 230  // Half period, unrelated to system clock
) (
  input  wire logic run_i,  // 1 oscillates, 0 failed
  output logic      osc_o   // Oscillator pin
);
  // A dead crystal sticks high, so no falling edge sets the latch
  initial osc_o = 1'b1;
  always begin
    #(HALF_NS);
    osc_o = run_i ? ~osc_o : 1'b1;
  end
endmodule

// >>> verification/fail_safe_clock_monitor_tb_top.sv
// Self-checking bench for the fail-safe clock monitor
`timescale 1ns/1ps
module fail_safe_clock_monitor_tb_top;
  import clock_monitor_pkg::*;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  wb_req_t     wb_req_i = '0;
  logic        lf_osc  = 1'b0;
  logic        en_cfg  = 1'b1;
  osc_mode_t   osc_mode = CRYSTAL_MEDIUM_MODE;
  logic        sleep_i = 1'b0;
  logic        wake_i  = 1'b0;
  logic        ext_run = 1'b1;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, ext_clk, sys_ext, cpu_hold, irq_o;
  logic [2:0]  freq_o;
  logic [4:0]  tune_o;
  logic [7:0]  rd;
  int          error_cnt = 0;
  int          checks_done = 0;

  // Fast slow-source keeps a sample half period near 640 cycles
  always #25 clk_i = ~clk_i;
  always #500 lf_osc = ~lf_osc;

  ext_osc_model ext_osc_model_i (.run_i(ext_run), .osc_o(ext_clk));
  fail_safe_clock_monitor #(.STARTUP_CYCLES(8)) fail_safe_clock_monitor_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk), .low_freq_internal_osc_i(lf_osc),
    .fail_safe_enable_cfg_i(en_cfg), .osc_mode_i(osc_mode), .sleep_i(sleep_i),
    .wake_i(wake_i), .sys_clk_ext_o(sys_ext), .internal_freq_select_o(freq_o),
    .osc_tune_o(tune_o), .cpu_hold_o(cpu_hold), .irq_o(irq_o));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // Holds the request until ack is sampled; no fixed latency assumed
  task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wb_req_i <= '{1'b1, 1'b1, we, a, 4'h1, {24'h0, d}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o[7:0];
    if (n >= 50) chk("ack", 8'h01, 8'h00);
    wb_req_i <= '0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(nm, e, rd);
  endtask

  task automatic wait_ext(input logic v, input int lim);
    int n;
    n = 0;
    while (sys_ext !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk("sys_clk_ext_o", {7'h0, v}, {7'h0, sys_ext});
  endtask

  task automatic fail_now();
    ext_run <= 1'b0;
    wait_ext(1'b0, 4000);
    ext_run <= 1'b1;
  endtask

  task automatic do_reset(input logic en, input osc_mode_t m);
    rst_i <= 1'b1;
    en_cfg <= en;
    osc_mode <= m;
    ext_run <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic final_report();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    #3000000;
    error_cnt++;
    final_report();
  end

  initial begin
    for (int m = 0; m < 6; m++) begin
      do_reset(1'b1, osc_mode_t'(m));
      wait_ext(1'b1, (m > 2) ? 6 : 3000);
      fail_now();
    end
    do_reset(1'b1, CRYSTAL_MEDIUM_MODE);
    rdchk("control", ADDR_OSC_CONTROL, 8'h66);
    rdchk("tuning", ADDR_OSC_TUNING, TUNE_RESET);
    rdchk("int_enable", ADDR_INT_ENABLE_TWO, INT_RESET);
    rdchk("int_flag", ADDR_INT_FLAG_TWO, INT_RESET);
    rdchk("unmapped", 8'h10, 8'h00);
    wait_ext(1'b1, 3000);
    rdchk("status", ADDR_OSC_CONTROL, 8'h6E);
    xfer(1'b1, ADDR_OSC_TUNING, 8'hFF);
    rdchk("tuning", ADDR_OSC_TUNING, 8'h1F);
    chk("osc_tune_o", 8'h1F, {3'h0, tune_o});
    xfer(1'b1, ADDR_OSC_CONTROL, 8'h20);
    chk("freq_select", 8'h02, {5'h0, freq_o});
    xfer(1'b1, ADDR_INT_ENABLE_TWO, 8'hFF);
    rdchk("int_enable", ADDR_INT_ENABLE_TWO, INT_MASK);
    fail_now();
    rdchk("int_flag", ADDR_INT_FLAG_TWO, 8'h80);
    rdchk("status", ADDR_OSC_CONTROL, 8'h26);
    chk("irq_o", 8'h01, {7'h0, irq_o});
    xfer(1'b1, ADDR_INT_FLAG_TWO, 8'h00);
    rdchk("flag held", ADDR_INT_FLAG_TWO, 8'h80);
    xfer(1'b1, ADDR_INT_ENABLE_TWO, 8'h00);
    chk("irq masked", 8'h00, {7'h0, irq_o});
    repeat (1500) @(posedge clk_i);
    chk("still internal", 8'h00, {7'h0, sys_ext});
    xfer(1'b1, ADDR_OSC_CONTROL, 8'h21);
    xfer(1'b1, ADDR_OSC_CONTROL, 8'h20);
    wait_ext(1'b1, 3000);
    xfer(1'b1, ADDR_INT_FLAG_TWO, 8'h00);
    rdchk("flag clear", ADDR_INT_FLAG_TWO, 8'h00);
    fail_now();
    sleep_i <= 1'b1;
    @(posedge clk_i);
    sleep_i <= 1'b0;
    wait_ext(1'b0, 3);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    wait_ext(1'b1, 3000);
    do_reset(1'b0, CRYSTAL_HIGH_SPEED_MODE);
    repeat (2) @(posedge clk_i);
    chk("cpu_hold_o", 8'h01, {7'h0, cpu_hold});
    wait_ext(1'b1, 3000);
    ext_run <= 1'b0;
    repeat (2000) @(posedge clk_i);
    chk("no switch", 8'h01, {7'h0, sys_ext});
    rdchk("no flag", ADDR_INT_FLAG_TWO, 8'h00);
    final_report();
  end
endmodule

bind fail_safe_clock_monitor clock_monitor_props clock_monitor_props_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk_i),
  .low_freq_internal_osc_i(low_freq_internal_osc_i),
  .fail_safe_enable_cfg_i(fail_safe_enable_cfg_i), .osc_mode_i(osc_mode_i),
  .sleep_i(sleep_i), .wake_i(wake_i), .sys_clk_ext_o(sys_clk_ext_o),
  .internal_freq_select_o(internal_freq_select_o), .osc_tune_o(osc_tune_o),
  .cpu_hold_o(cpu_hold_o), .irq_o(irq_o));
